// file: src/sdram_ctl_params.svh
// constants and behaviour list for the sdram command block
//
// Behaviour
// - burst stop ends full-page burst only
// - burst stop: cs,we low, ras,cas high
// - read data released after cas latency
// - sequential order wraps within burst length
// - interleave order xors beat with start
// - a10 with read/write selects auto-precharge
// - read autoprecharge starts cas latency early
// - write autoprecharge starts two clocks after
// - precharge: cs,ras,we low, cas high
// - self refresh entry decode, banks idle
// - self refresh ignores all but clock enable
// - clock enable high exits self refresh
// - clock enable low, banks idle, enters power down
// - nop and deselect never end bursts
// - clock suspend freezes one clock later
`ifndef SDRAM_CTL_PARAMS_SVH
`define SDRAM_CTL_PARAMS_SVH

// ------------------------------------------------------------
// burst length codes (mode field)
// ------------------------------------------------------------
`define BL_CODE_1 3'h0
`define BL_CODE_2 3'h1
`define BL_CODE_4 3'h2
`define BL_CODE_8 3'h3
`define BL_CODE_FULL 3'h7
// ------------------------------------------------------------
// address fields and timing
// ------------------------------------------------------------
`define AP_BIT 10
`define COL_W 8
`define WR_RECOVERY_CLKS 2
`define CLK_PERIOD_NS 25

`endif

// file: src/sdram_ctl_pkg.sv
// types shared by the sdram command block
`default_nettype none
package sdram_ctl_pkg;
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
    } cmd_pins_t;

    typedef enum logic [3:0] {
        ST_RUN = 4'h1,
        ST_SUSPEND = 4'h2,
        ST_POWER_DOWN = 4'h4,
        ST_SELF_REFRESH = 4'h8
    } pwr_state_t;

    typedef enum logic [2:0] {
        BU_IDLE = 3'h1,
        BU_READ = 3'h2,
        BU_WRITE = 3'h4
    } burst_state_t;
endpackage
`default_nettype wire

// file: src/sdram_ctl.sv
// command decode, burst sequencing and power states of the sdram
`timescale 1ns/1ps
`default_nettype none
`include "sdram_ctl_params.svh"
module sdram_ctl
    import sdram_ctl_pkg::*;
(
    input wire logic sys_clk, // device clock
    input wire logic nrst, // async reset, active low
    input wire logic cke, // clock enable pin
    input wire cmd_pins_t cmd, // command pins
    input wire logic [11:0] addr, // address pins
    input wire logic bank_select_bit0, // bank select low
    input wire logic bank_select_bit1, // bank select high
    input wire logic [2:0] burst_len_code, // programmed burst length
    input wire logic interleave_mode, // 1: interleave order
    input wire logic [1:0] cas_latency, // programmed cas latency
    input wire logic [3:0] bank_open_set, // activate pulses per bank
    output logic [3:0] bank_open, // banks currently open
    output logic [3:0] precharge_start, // internal precharge pulse
    output logic burst_active, // burst in progress
    output logic burst_is_write, // burst direction
    output logic [`COL_W-1:0] col_addr, // column of current beat
    output logic dq_oe, // read data drivers enabled
    output logic suspended, // clock suspend in force
    output logic power_down, // power down in force
    output logic self_refresh // self refresh in force
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [17:0] s1_r, s2_r;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            // deselect with clock enabled, so no false power-down entry
            s1_r <= 18'h0003E;
            s2_r <= 18'h0003E;
        end else begin
            s1_r <= {addr, cmd, cke, bank_select_bit1};
            s2_r <= s1_r;
        end
    end
    logic [11:0] a_s;
    cmd_pins_t c_s;
    logic cke_s;
    logic [1:0] bs_s;
    assign a_s = s2_r[17:6];
    assign c_s = s2_r[5:2];
    assign cke_s = s2_r[1];
    // bit0 is sampled alongside; kept apart to match pin naming
    logic bs0_1_r, bs0_2_r;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            bs0_1_r <= 1'b0;
            bs0_2_r <= 1'b0;
        end else begin
            bs0_1_r <= bank_select_bit0;
            bs0_2_r <= bs0_1_r;
        end
    end
    assign bs_s = {s2_r[0], bs0_2_r};

    // ------------------------------------------------------------
    // power state and command decode
    // ------------------------------------------------------------
    pwr_state_t pst_r, pst_nxt;
    logic cke_prev_r, cke_prev_nxt;
    logic live; // commands are honoured this cycle
    logic sel;
    logic is_read, is_write, is_stop, is_pre, is_sref;
    always_comb begin
        sel = !c_s.cs_n;
        // nop and deselect decode to nothing, so bursts go on
        is_read = sel && c_s.ras_n && !c_s.cas_n && c_s.we_n;
        is_write = sel && c_s.ras_n && !c_s.cas_n && !c_s.we_n;
        is_stop = sel && c_s.ras_n && c_s.cas_n && !c_s.we_n;
        is_pre = sel && !c_s.ras_n && c_s.cas_n && !c_s.we_n;
        is_sref = sel && !c_s.ras_n && !c_s.cas_n && c_s.we_n;
        live = (pst_r == ST_RUN) && cke_prev_r;
        cke_prev_nxt = cke_s;
        pst_nxt = pst_r;
        unique case (pst_r)
            ST_RUN: begin
                if (cke_prev_r && !cke_s) begin
                    if (is_sref && bank_open == 4'h0 && !burst_active)
                        pst_nxt = ST_SELF_REFRESH;
                    else if (bank_open != 4'h0 || burst_active)
                        pst_nxt = ST_SUSPEND;
                    else
                        pst_nxt = ST_POWER_DOWN;
                end
            end
            // one cycle delay on exit: cke high seen, run next edge
            ST_SUSPEND: if (cke_s) pst_nxt = ST_RUN;
            ST_POWER_DOWN: if (cke_s) pst_nxt = ST_RUN;
            // only clock enable is watched here
            ST_SELF_REFRESH: if (cke_s) pst_nxt = ST_RUN;
            default: pst_nxt = ST_RUN;
        endcase
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pst_r <= ST_RUN;
            cke_prev_r <= 1'b1;
        end else begin
            pst_r <= pst_nxt;
            cke_prev_r <= cke_prev_nxt;
        end
    end
    // freeze lags cke low by one clock
    logic run;
    assign run = (pst_r == ST_RUN);

    // ------------------------------------------------------------
    // burst sequencer
    // ------------------------------------------------------------
    burst_state_t bst_r, bst_nxt;
    logic [`COL_W-1:0] start_r, start_nxt;
    logic [`COL_W-1:0] beat_r, beat_nxt;
    logic ap_r, ap_nxt;
    logic [1:0] bank_r, bank_nxt;
    logic [2:0] drain_r, drain_nxt; // read drivers stay on after stop
    logic [1:0] wrec_r, wrec_nxt;
    logic [1:0] wbank_r, wbank_nxt; // bank owed a recovery precharge
    logic [3:0] pre_nxt;
    logic [`COL_W-1:0] mask, last_beat, beat_sum, ap_lead;
    logic full;
    always_comb begin
        full = (burst_len_code == `BL_CODE_FULL);
        unique case (burst_len_code)
            `BL_CODE_2: mask = 8'h01;
            `BL_CODE_4: mask = 8'h03;
            `BL_CODE_8: mask = 8'h07;
            `BL_CODE_FULL: mask = 8'hFF;
            default: mask = 8'h00;
        endcase
        last_beat = mask;
        // bursts no longer than the latency precharge from their first beat
        if (last_beat < {6'h0, cas_latency})
            ap_lead = 8'h00;
        else
            ap_lead = last_beat - {6'h0, cas_latency};
        // count inside the burst window only, no carry above it
        beat_sum = (start_r & mask) + beat_r;
        if (interleave_mode && !full)
            col_addr = (start_r & ~mask) | ((start_r ^ beat_r) & mask);
        else
            col_addr = (start_r & ~mask) | (beat_sum & mask);
        bst_nxt = bst_r;
        start_nxt = start_r;
        beat_nxt = beat_r;
        ap_nxt = ap_r;
        bank_nxt = bank_r;
        drain_nxt = (drain_r != 3'h0) ? drain_r - 3'h1 : 3'h0;
        wrec_nxt = (wrec_r != 2'h0) ? wrec_r - 2'h1 : 2'h0;
        wbank_nxt = wbank_r;
        pre_nxt = 4'h0;
        // own bank copy: a new burst elsewhere must not steal the precharge
        if (wrec_r == 2'h1)
            pre_nxt[wbank_r] = 1'b1;
        if (live && is_pre) begin
            if (a_s[`AP_BIT])
                pre_nxt = 4'hF;
            else
                pre_nxt[bs_s] = 1'b1;
        end
        if (run && bst_r != BU_IDLE) begin
            beat_nxt = beat_r + 8'h01;
            // read autoprecharge: lead equal to cas latency
            if (ap_r && bst_r == BU_READ && !full && beat_r == ap_lead)
                pre_nxt[bank_r] = 1'b1;
            if (beat_r == last_beat && !full) begin
                bst_nxt = BU_IDLE;
                if (bst_r == BU_READ)
                    drain_nxt = {1'b0, cas_latency};
                // pulse is registered, so the count is one short
                if (ap_r && bst_r == BU_WRITE) begin
                    wrec_nxt = 2'(`WR_RECOVERY_CLKS - 1);
                    wbank_nxt = bank_r;
                end
            end
        end
        if (live && is_stop && full && bst_r != BU_IDLE) begin
            // bank stays open, page kept
            if (bst_r == BU_READ)
                drain_nxt = {1'b0, cas_latency};
            bst_nxt = BU_IDLE;
        end
        if (live && (is_read || is_write)) begin
            bst_nxt = is_read ? BU_READ : BU_WRITE;
            start_nxt = a_s[`COL_W-1:0];
            beat_nxt = 8'h00;
            ap_nxt = a_s[`AP_BIT] && !full;
            bank_nxt = bs_s;
            // burst length 1 finishes on its first beat
        end
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            bst_r <= BU_IDLE;
            start_r <= 8'h00;
            beat_r <= 8'h00;
            ap_r <= 1'b0;
            bank_r <= 2'h0;
            drain_r <= 3'h0;
            wrec_r <= 2'h0;
            wbank_r <= 2'h0;
            precharge_start <= 4'h0;
        end else begin
            bst_r <= bst_nxt;
            start_r <= start_nxt;
            beat_r <= beat_nxt;
            ap_r <= ap_nxt;
            bank_r <= bank_nxt;
            drain_r <= drain_nxt;
            wrec_r <= wrec_nxt;
            wbank_r <= wbank_nxt;
            precharge_start <= pre_nxt;
        end
    end

    // ------------------------------------------------------------
    // bank open flags: activate sets win over precharge clears
    // ------------------------------------------------------------
    logic [3:0] open_nxt;
    assign open_nxt = (bank_open & ~precharge_start) | bank_open_set;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst)
            bank_open <= 4'h0;
        else
            bank_open <= open_nxt;
    end

    assign burst_active = (bst_r != BU_IDLE);
    assign burst_is_write = (bst_r == BU_WRITE);
    assign dq_oe = (bst_r == BU_READ) || (drain_r != 3'h0);
    assign suspended = (pst_r == ST_SUSPEND);
    assign power_down = (pst_r == ST_POWER_DOWN);
    assign self_refresh = (pst_r == ST_SELF_REFRESH);
endmodule
`default_nettype wire

// file: tb/sdram_ctl_props.sv
// assertions on the ports of the sdram command block
`timescale 1ns/1ps
`default_nettype none
module sdram_ctl_props (
    input wire logic sys_clk, // device clock
    input wire logic nrst, // reset, active low
    input wire logic cke, // clock enable pin
    input wire logic [3:0] bank_open, // open banks
    input wire logic [3:0] precharge_start, // precharge pulses
    input wire logic burst_active, // burst running
    input wire logic [7:0] col_addr, // beat column
    input wire logic dq_oe, // read drivers on
    input wire logic suspended, // clock suspend
    input wire logic power_down, // power down
    input wire logic self_refresh // self refresh
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    one_state_a: assert property ($onehot0({suspended, power_down,
        self_refresh})) else $error("two power states at once");
    sr_hold_a: assert property (self_refresh && !cke && !$past(cke)
        && !$past(cke, 2) |=> self_refresh) else $error("left self refresh");
    sr_exit_a: assert property ($rose(cke) && self_refresh
        |-> ##[1:4] !self_refresh) else $error("self refresh kept");
    sleep_idle_a: assert property (power_down || self_refresh
        |-> !burst_active) else $error("burst while asleep");
    rd_release_a: assert property ($fell(burst_active) && !suspended
        |-> ##[1:4] !dq_oe) else $error("data drivers held");
    bank_close_a: assert property (precharge_start[0]
        |-> ##[0:1] !bank_open[0]) else $error("bank left open");
    pre_pulse_a: assert property (|precharge_start
        |=> precharge_start == 4'h0) else $error("precharge pulse long");
    freeze_a: assert property (suspended && $past(suspended)
        |-> $stable(col_addr)) else $error("column moved in suspend");
    // main scenarios reached
    susp_c: cover property ($rose(suspended));
    sref_c: cover property ($rose(self_refresh));
    pre_c: cover property (|precharge_start);
endmodule
bind sdram_ctl sdram_ctl_props i_props (.sys_clk, .nrst, .cke, .bank_open,
    .precharge_start, .burst_active, .col_addr, .dq_oe, .suspended,
    .power_down, .self_refresh);
`default_nettype wire

// file: tb/sdram_host_model.sv
// controller-side pin driver for the sdram command block
`timescale 1ns/1ps
`default_nettype none
module sdram_host_model
    import sdram_ctl_pkg::*;
(
    input wire logic sys_clk, // device clock
    output var logic cke, // clock enable pin
    output var cmd_pins_t cmd, // command pins
    output var logic [11:0] addr, // address pins
    output var logic [1:0] bank // bank select pins
);
    // idle pins: deselect with the clock enabled
    initial begin
        cke = 1'b1;
        cmd = 4'hF;
        addr = 12'h000;
        bank = 2'h0;
    end
    // one command for one edge; address flips after so nothing stale lingers
    task automatic issue(input logic [3:0] c, input logic [11:0] a,
        input logic [1:0] b);
        @(negedge sys_clk);
        cmd = c;
        addr = a;
        bank = b;
        @(negedge sys_clk);
        cmd = 4'hF;
        addr = ~a;
    endtask
    // clock enable change, with a command on the same edge
    task automatic set_cke(input logic v, input logic [3:0] c);
        @(negedge sys_clk);
        cke = v;
        cmd = c;
        @(negedge sys_clk);
        cmd = 4'hF;
    endtask
endmodule
`default_nettype wire

// file: tb/sdram_ctl_bench.sv
// self-checking bench for the sdram command block
`timescale 1ns/1ps
`default_nettype none
module sdram_ctl_bench;
    import sdram_ctl_pkg::*;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic cke, b_act, b_wr, dq_oe, susp, pdn, sref, ilv = 1'b0;
    cmd_pins_t cmd;
    logic [11:0] addr;
    logic [1:0] bank;
    logic [2:0] bl = 3'h2;
    logic [1:0] cl = 2'h2;
    logic [3:0] open_set = 4'h0, bank_open, pre;
    logic [7:0] col, c;
    int n_mismatch = 0, tests_run = 0, cyc = 0, act_cnt = 0;
    always #12.5 sys_clk = ~sys_clk;
    sdram_ctl i_dut (.sys_clk, .nrst, .cke, .cmd, .addr,
        .bank_select_bit0(bank[0]), .bank_select_bit1(bank[1]),
        .burst_len_code(bl), .interleave_mode(ilv), .cas_latency(cl),
        .bank_open_set(open_set), .bank_open, .precharge_start(pre),
        .burst_active(b_act), .burst_is_write(b_wr), .col_addr(col),
        .dq_oe, .suspended(susp), .power_down(pdn), .self_refresh(sref));
    sdram_host_model i_host (.sys_clk, .cke, .cmd, .addr, .bank);
    // beats counted on the edge so tasks may clear at the falling edge
    always @(posedge sys_clk) begin
        cyc++;
        act_cnt += 32'(b_act === 1'b1);
        if (cyc == 3000) begin
            n_mismatch++;
            print_verdict;
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic open_banks(input logic [3:0] m);
        open_set = m;
        tick(1);
        open_set = 4'h0;
    endtask
    // start column b5 makes every length wrap in its low bits
    task automatic test_order;
        int i, j;
        logic [7:0] m;
        for (j = 0; j < 6; j++) begin
            bl = 3'(j % 3 + 1);
            ilv = 1'(j / 3);
            m = 8'((2 << (j % 3)) - 1);
            open_banks(4'h1);
            i_host.issue(4'h5, 12'h0B5, 2'h0);
            for (i = 0; i < 10 && b_act !== 1'b1; i++) tick(1);
            for (i = 0; i < (2 << (j % 3)); i++) begin
                check(col, ilv ? 8'hB5 ^ 8'(i) :
                    (8'hB5 & ~m) | ((8'hB5 + 8'(i)) & m));
                tick(1);
            end
        end
        $display("order test done");
    endtask
    // stop refused on bl4, honoured on full page; nop never ends bl8
    task automatic test_stop;
        int k;
        for (k = 0; k < 3; k++) begin
            bl = k == 0 ? 3'h2 : {k[0], 2'h3};
            act_cnt = 0;
            i_host.issue(4'h5, 12'h0FE, 2'h0);
            i_host.issue(k < 2 ? 4'h6 : 4'h7, 12'h000, 2'h0);
            // drivers let go cas latency cycles after the stop
            tick(3);
            if (k == 1) check(dq_oe, 1'b1);
            tick(1);
            if (k == 1) check(dq_oe, 1'b0);
            tick(8);
            if (k == 1) check(16'(act_cnt < 8), 16'h1);
            else check(16'(act_cnt), 16'(4 << k[1]));
        end
        check({dq_oe, bank_open[0]}, 2'b01);
        $display("stop test done");
    endtask
    // read, write, then read at latency 3, all with auto-precharge
    task automatic test_ap;
        int k, gap, hit;
        bl = 3'h2;
        open_banks(4'hC);
        for (k = 0; k < 3; k++) begin
            if (k == 2) begin
                cl = 2'h3;
                open_banks(4'h4);
            end
            i_host.issue({3'h2, ~k[0]}, 12'h400, {1'b1, k[0]});
            gap = 0;
            hit = -1;
            // reads precharge cas latency beats before the end, writes two clocks after it
            repeat (14) begin
                if (b_act === 1'b1) check(b_wr, k[0]);
                gap = b_act ? 0 : gap + 1;
                if (pre[{1'b1, k[0]}]) hit = k[0] ? gap : 0;
                if (!k[0] && hit >= 0 && b_act) hit++;
                tick(1);
            end
            check(16'(hit), k[0] ? 16'h2 : 16'(cl));
        end
        cl = 2'h2;
        check(bank_open, 4'h1);
        $display("auto precharge test done");
    endtask
    task automatic test_pre;
        int b;
        for (b = 0; b < 5; b++) begin
            open_banks(4'hF);
            i_host.issue(4'h2, b == 4 ? 12'h400 : 12'h000, 2'(b + b / 4));
            tick(5);
            check(bank_open, b == 4 ? 4'h0 : 4'hF & ~(4'h1 << b));
        end
        $display("precharge test done");
    endtask
    // suspend mid-burst, then power down, then self refresh
    task automatic test_power;
        int i;
        bl = 3'h3;
        open_banks(4'h1);
        i_host.issue(4'h5, 12'h010, 2'h0);
        for (i = 0; i < 10 && b_act !== 1'b1; i++) tick(1);
        i_host.set_cke(1'b0, 4'hF);
        tick(3);
        c = col;
        tick(2);
        check({susp, col}, {1'b1, c});
        i_host.issue(4'h2, 12'h400, 2'h0);
        i_host.set_cke(1'b1, 4'h7);
        tick(14);
        check({susp, b_act, bank_open}, 6'h01);
        i_host.issue(4'h2, 12'h400, 2'h0);
        i_host.set_cke(1'b0, 4'hF);
        tick(4);
        check(pdn, 1'b1);
        i_host.set_cke(1'b1, 4'h7);
        tick(4);
        check(pdn, 1'b0);
        // no refresh bursts are kept, so none are owed around this entry
        i_host.set_cke(1'b0, 4'h1);
        i_host.issue(4'h5, 12'h000, 2'h0);
        tick(4);
        check({sref, b_act}, 2'b10);
        i_host.set_cke(1'b1, 4'h7);
        tick(6);
        check(sref, 1'b0);
        $display("power test done");
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        tick(2);
        nrst = 1'b1;
        test_order;
        test_stop;
        test_ap;
        test_pre;
        test_power;
        print_verdict;
    end
endmodule
`default_nettype wire
